/* core/mue_map.vh */
/*
  Constants for the MIDI UART-mode emulator: port offsets, status bit
  positions, command codes, reply bytes and serial timing.
  Assumes a 25 MHz system clock.
*/
`ifndef MUE_MAP_VH
`define MUE_MAP_VH

// ---------------------------------------------------------------
// Port offsets
// ---------------------------------------------------------------
`define MUE_OFS_DATA        1'b0
`define MUE_OFS_CMD_STAT    1'b1

// ---------------------------------------------------------------
// Status bits
// ---------------------------------------------------------------
`define MUE_STAT_TXFULL_BIT 6
`define MUE_STAT_RXEMPTY_BIT 7

// ---------------------------------------------------------------
// Commands and replies
// ---------------------------------------------------------------
`define MUE_CMD_ENTER_UART  8'h3f
`define MUE_CMD_EXIT_UART   8'hff
`define MUE_CMD_QRY_LO      8'ha0
`define MUE_CMD_QRY_HI      8'ha7
`define MUE_CMD_QRY_AB      8'hab
`define MUE_CMD_QRY_AC      8'hac
`define MUE_CMD_QRY_AD      8'had
`define MUE_CMD_QRY_AF      8'haf
`define MUE_ACK_BYTE        8'hfe
`define MUE_REPLY_ZERO      8'h00
`define MUE_REPLY_AC        8'h15
`define MUE_REPLY_AD        8'h01
`define MUE_REPLY_AF        8'h64

// ---------------------------------------------------------------
// Serial timing and FIFO sizing
// ---------------------------------------------------------------
`define MUE_CLK_HZ          25000000
`define MUE_BAUD_HZ         31250
`define MUE_BIT_CYCLES      (`MUE_CLK_HZ / `MUE_BAUD_HZ)
`define MUE_HALF_CYCLES     (`MUE_BIT_CYCLES / 2)
`define MUE_FIFO_DEPTH      16
`define MUE_FIFO_AW         4

`endif

/* core/mue_fifo.v */
/*
  Byte FIFO with valid/ready on both sides, parameterised width/depth.
  Optional overwrite of the last slot when full, for the receive path.
  Assumes one clock and a synchronous consumer.
*/
`timescale 1ns/100ps
`default_nettype none

module mue_fifo #(
  parameter W  = 8,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire          clk,
  input  wire          rst_b,
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  input  wire          ovr_en,
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data,
  output wire          full,
  output wire          empty
);

  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         pop;
  wire         ovr;

  assign full      = (cnt_q == D[AW:0]);
  assign empty     = (cnt_q == {(AW+1){1'b0}});
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_q];
  assign pop       = out_valid && out_ready;
  assign push      = in_valid && (!full || pop);
  // Full with no pop: newest byte replaces the last slot
  assign ovr       = in_valid && full && !pop && ovr_en;

  always @(posedge clk) begin
    if (push)
      mem[wr_q] <= in_data;
    else if (ovr)
      mem[wr_q - 1'b1] <= in_data;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule // mue_fifo

`default_nettype wire

/* core/mue_uart.v */
/*
  MIDI UART-mode emulator: data port and command/status port on a
  byte-wide host port, transmit and receive FIFOs, 31.25 kbaud serial.
  Assumes host strobes are one-cycle pulses synchronous to clk and the
  serial input is already synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mue_map.vh"

// Behaviour
// - Reset leaves block in non-UART mode
// - Non-UART data writes are discarded
// - Non-UART data read returns FIFO head, no pop
// - Command 3Fh enters UART, acks FEh
// - Query commands ack FEh plus reply byte
// - Replies 15h, 01h, 64h for AC/AD/AF
// - Other non-UART commands only ack FEh
// - UART data writes queue and transmit
// - Status bit 6 shows transmit full in UART mode
// - UART data read pops receive FIFO
// - Serial bytes stored, last slot overwritten
// - Status bit 7 tracks receive FIFO
// - Command FFh leaves UART mode
// - Other UART-mode commands are ignored
// - 31.25 kbaud, start, 8 data, stop
// - Sixteen-byte FIFO per direction
// - Full reads 1; empty reads 1
// - Interrupt on receive; data read clears
module mue_uart (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       port_addr,
  input  wire       port_wr,
  input  wire       port_rd,
  input  wire [7:0] port_wdata,
  output reg  [7:0] port_rdata,
  output reg        midi_irq,
  output reg        uart_mode,
  output reg        midi_serial_out,
  input  wire       midi_serial_in
);

  // ---------------------------------------------------------------
  // Bit timing
  // ---------------------------------------------------------------
  // Timers count down to zero, so reload is one less than the span
  localparam integer BIT_CYC_I  = `MUE_BIT_CYCLES - 1;
  localparam integer HALF_CYC_I = `MUE_HALF_CYCLES - 1;
  localparam [12:0]  BIT_CNT    = BIT_CYC_I[12:0];
  localparam [12:0]  HALF_CNT   = HALF_CYC_I[12:0];

  // ---------------------------------------------------------------
  // Transmit shifter states
  // ---------------------------------------------------------------
  localparam [1:0] TX_IDLE  = 2'b01;
  localparam [1:0] TX_SHIFT = 2'b10;

  // ---------------------------------------------------------------
  // Receive states
  // ---------------------------------------------------------------
  localparam [2:0] RX_IDLE  = 3'b001;
  localparam [2:0] RX_START = 3'b010;
  localparam [2:0] RX_DATA  = 3'b100;

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  reg  [1:0]  tx_st_q;
  reg  [12:0] tx_cnt_q;
  reg  [3:0]  tx_bit_q;
  reg  [9:0]  tx_sh_q;
  reg  [2:0]  rx_st_q;
  reg  [12:0] rx_cnt_q;
  reg  [3:0]  rx_bit_q;
  reg  [7:0]  rx_sh_q;
  reg         rx_done_q;
  reg  [7:0]  rx_byte_q;
  reg         reply_pend_q;
  reg  [7:0]  reply_q;
  reg  [7:0]  last_rx_q;
  reg         rxin_q;

  // ---------------------------------------------------------------
  // Host port decode
  // ---------------------------------------------------------------
  wire        data_wr  = port_wr && (port_addr == `MUE_OFS_DATA);
  wire        cmd_wr   = port_wr && (port_addr == `MUE_OFS_CMD_STAT);
  wire        data_rd  = port_rd && (port_addr == `MUE_OFS_DATA);

  wire        txf_valid;
  wire [7:0]  txf_data;
  wire        txf_full;
  wire        txf_pop;
  wire        rxf_valid;
  wire [7:0]  rxf_data;
  wire        rxf_empty;
  wire        rxf_pop;
  reg         rxf_push;
  reg  [7:0]  rxf_wdata;
  reg         rxf_ovr;

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  wire is_query = ((port_wdata >= `MUE_CMD_QRY_LO) && (port_wdata <= `MUE_CMD_QRY_HI))
                  || (port_wdata == `MUE_CMD_QRY_AB) || (port_wdata == `MUE_CMD_QRY_AC)
                  || (port_wdata == `MUE_CMD_QRY_AD) || (port_wdata == `MUE_CMD_QRY_AF);
  reg  [7:0] reply_d;

  always @* begin
    case (port_wdata)
      `MUE_CMD_QRY_AC: reply_d = `MUE_REPLY_AC;
      `MUE_CMD_QRY_AD: reply_d = `MUE_REPLY_AD;
      `MUE_CMD_QRY_AF: reply_d = `MUE_REPLY_AF;
      default:         reply_d = `MUE_REPLY_ZERO;
    endcase
  end

  // ---------------------------------------------------------------
  // Receive FIFO source arbitration
  // ---------------------------------------------------------------
  // One push per cycle: ack first, then pending reply, then serial byte.
  // A serial byte that collides waits in rx_done_q until no ack or reply is pushed.
  // Every non-UART command acks
  wire ack_now = cmd_wr && !uart_mode;

  always @* begin
    rxf_push  = 1'b0;
    rxf_wdata = `MUE_ACK_BYTE;
    if (ack_now) begin
      rxf_push  = 1'b1;
      rxf_wdata = `MUE_ACK_BYTE;
    end else if (reply_pend_q) begin
      rxf_push  = 1'b1;
      rxf_wdata = reply_q;
    end else if (rx_done_q) begin
      rxf_push  = 1'b1;
      rxf_wdata = rx_byte_q;
    end
    rxf_ovr = 1'b1;
  end

  // Serial byte keeps its holding flag until it is really pushed
  wire rx_taken = rx_done_q && !ack_now && !reply_pend_q;

  assign rxf_pop = data_rd && uart_mode;

  // ---------------------------------------------------------------
  // Mode and host-side state
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      uart_mode    <= 1'b0;
      reply_pend_q <= 1'b0;
      reply_q      <= 8'h00;
      last_rx_q    <= 8'h00;
      midi_irq     <= 1'b0;
      port_rdata   <= 8'h00;
    end else begin
      if (cmd_wr) begin
        if (!uart_mode) begin
          if (port_wdata == `MUE_CMD_ENTER_UART)
            uart_mode <= 1'b1;
          // Queue second reply byte
          // A command in the very next cycle replaces the pending reply
          reply_pend_q <= is_query;
          reply_q      <= reply_d;
        end else if (port_wdata == `MUE_CMD_EXIT_UART) begin
          uart_mode <= 1'b0;
        end
      end else if (reply_pend_q) begin
        reply_pend_q <= 1'b0;
      end
      if (rxf_pop)
        last_rx_q <= rxf_data;
      if (rxf_push)
        midi_irq <= 1'b1;
      else if (data_rd)
        midi_irq <= 1'b0;
      if (port_rd) begin
        if (port_addr == `MUE_OFS_CMD_STAT) begin
          // Live status flags
          // Transmit flag masked outside UART mode, where writes are dropped
          port_rdata <= 8'h00;
          port_rdata[`MUE_STAT_TXFULL_BIT]  <= uart_mode && txf_full;
          port_rdata[`MUE_STAT_RXEMPTY_BIT] <= rxf_empty;
        end else if (uart_mode) begin
          port_rdata <= rxf_valid ? rxf_data : last_rx_q;
        end else begin
          port_rdata <= rxf_valid ? rxf_data : last_rx_q;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // FIFOs
  // ---------------------------------------------------------------
  // Sixteen-entry transmit FIFO
  mue_fifo #(.W(8), .D(`MUE_FIFO_DEPTH), .AW(`MUE_FIFO_AW)) u_txf (
    .clk       (clk),
    .rst_b     (rst_b),
    // Queue only in UART mode
    // A write while full is lost unless the transmitter pops in that cycle; the host polls the flag first
    .in_valid  (data_wr && uart_mode),
    .in_ready  (),
    .in_data   (port_wdata),
    .ovr_en    (1'b0),
    .out_valid (txf_valid),
    .out_ready (txf_pop),
    .out_data  (txf_data),
    .full      (txf_full),
    .empty     ()
  );

  mue_fifo #(.W(8), .D(`MUE_FIFO_DEPTH), .AW(`MUE_FIFO_AW)) u_rxf (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (rxf_push),
    .in_ready  (),
    .in_data   (rxf_wdata),
    .ovr_en    (rxf_ovr),
    .out_valid (rxf_valid),
    .out_ready (rxf_pop),
    .out_data  (rxf_data),
    .full      (),
    .empty     (rxf_empty)
  );

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  // Take the next byte whenever the shifter is idle and the FIFO not empty
  assign txf_pop = (tx_st_q == TX_IDLE) && txf_valid;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_q         <= TX_IDLE;
      tx_cnt_q        <= 13'h0000;
      tx_bit_q        <= 4'h0;
      tx_sh_q         <= 10'h3ff;
      midi_serial_out <= 1'b1;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          midi_serial_out <= 1'b1;
          if (txf_valid) begin
            tx_sh_q  <= {1'b1, txf_data, 1'b0};
            tx_cnt_q <= BIT_CNT;
            tx_bit_q <= 4'h0;
            tx_st_q  <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          midi_serial_out <= tx_sh_q[0];
          if (tx_cnt_q == 13'h0000) begin
            tx_cnt_q <= BIT_CNT;
            tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
            if (tx_bit_q == 4'h9)
              tx_st_q <= TX_IDLE;
            else
              tx_bit_q <= tx_bit_q + 4'h1;
          end else begin
            tx_cnt_q <= tx_cnt_q - 13'h0001;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  // Samples mid-bit; a false start shorter than half a bit is dropped.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxin_q    <= 1'b1;
      rx_st_q   <= RX_IDLE;
      rx_cnt_q  <= 13'h0000;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h00;
      rx_done_q <= 1'b0;
      rx_byte_q <= 8'h00;
    end else begin
      rxin_q <= midi_serial_in;
      if (rx_taken)
        rx_done_q <= 1'b0;
      case (rx_st_q)
        RX_IDLE: begin
          if (!rxin_q) begin
            rx_cnt_q <= HALF_CNT;
            rx_st_q  <= RX_START;
          end
        end
        RX_START: begin
          if (rx_cnt_q == 13'h0000) begin
            rx_cnt_q <= BIT_CNT;
            rx_bit_q <= 4'h0;
            rx_st_q  <= rxin_q ? RX_IDLE : RX_DATA;
          end else begin
            rx_cnt_q <= rx_cnt_q - 13'h0001;
          end
        end
        RX_DATA: begin
          if (rx_cnt_q == 13'h0000) begin
            rx_cnt_q <= BIT_CNT;
            if (rx_bit_q == 4'h8) begin
              rx_st_q <= RX_IDLE;
              if (rxin_q) begin
                rx_done_q <= 1'b1;
                rx_byte_q <= rx_sh_q;
              end
            end else begin
              rx_sh_q  <= {rxin_q, rx_sh_q[7:1]};
              rx_bit_q <= rx_bit_q + 4'h1;
            end
          end else begin
            rx_cnt_q <= rx_cnt_q - 13'h0001;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

endmodule // mue_uart

`default_nettype wire

/* bench/mue_midi_dev.sv */
/*
  Behavioural MIDI instrument on the far side of the serial link.
  Assumes the 25 MHz bench clock; the line idles high between frames.
*/
`timescale 1ns/100ps
`default_nettype none

module mue_midi_dev (
  input  wire logic clk,
  input  wire logic line_in,
  output var  logic line_out
);
  localparam int BIT_CYC = 800;
  logic [7:0] rx_q [$];
  logic [7:0] b;

  initial line_out = 1'b1;

  // ---------------------------------------------------------------
  // Frame send and receive
  // ---------------------------------------------------------------
  // start, LSB first, stop
  task automatic send_byte(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      line_out <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
  endtask

  always begin
    @(negedge line_in);
    repeat (BIT_CYC / 2) @(posedge clk);
    if (!line_in) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk);
        b[i] = line_in;
      end
      repeat (BIT_CYC) @(posedge clk);
      if (line_in) rx_q.push_back(b);
    end
  end
endmodule // mue_midi_dev

`default_nettype wire

/* bench/mue_uart_props.sv */
/*
  Port-level checker for the emulator top; bound below its endmodule.
  Assumes one clock domain and the async active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none

module mue_uart_props (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       port_addr,
  input wire logic       port_wr,
  input wire logic       port_rd,
  input wire logic [7:0] port_wdata,
  input wire logic [7:0] port_rdata,
  input wire logic       midi_irq,
  input wire logic       uart_mode,
  input wire logic       midi_serial_out,
  input wire logic       midi_serial_in
);
  logic        seen_q;
  logic [12:0] low_q;

  // Low run length, so bit timing needs no long repetition
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_q <= 1'b0;
      low_q  <= 13'h0000;
    end else begin
      if (port_wr && !port_addr && uart_mode) seen_q <= 1'b1;
      low_q <= midi_serial_out ? 13'h0000 : low_q + 13'h0001;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  reset_mode_a: assert property (
    !$past(rst_b) |-> !uart_mode && !midi_irq && midi_serial_out)
    else $error("bad state after reset");
  mode_enter_a: assert property (
    port_wr && port_addr && !uart_mode && port_wdata == 8'h3f |=> uart_mode && midi_irq)
    else $error("enter command not honoured");
  mode_exit_a: assert property (
    port_wr && port_addr && uart_mode && port_wdata == 8'hff |=> !uart_mode)
    else $error("exit command not honoured");
  mode_hold_a: assert property (
    !(port_wr && port_addr && (port_wdata == 8'h3f || port_wdata == 8'hff))
    |=> $stable(uart_mode))
    else $error("mode changed without cause");
  cmd_irq_a: assert property (
    port_wr && port_addr && !uart_mode |=> midi_irq)
    else $error("command not acknowledged");
  stat_bits_a: assert property (
    port_rd && port_addr |=> port_rdata[5:0] == 6'h00 && ($past(uart_mode) || !port_rdata[6]))
    else $error("status spare bits wrong");
  irq_data_a: assert property (
    port_rd && port_addr && midi_irq |=> !port_rdata[7])
    else $error("interrupt with empty receive buffer");
  rdata_hold_a: assert property (
    !port_rd |=> $stable(port_rdata))
    else $error("read data moved without read");
  tx_quiet_a: assert property (
    !seen_q |-> midi_serial_out)
    else $error("serial activity without data write");
  bit_time_a: assert property (
    $rose(midi_serial_out) |-> low_q % 13'h0320 == 13'h0000)
    else $error("low run not whole bit times");

  cover property (port_wr && port_addr && port_wdata == 8'h3f);
  cover property ($rose(midi_irq));
  cover property ($fell(midi_serial_out));
endmodule // mue_uart_props

bind mue_uart mue_uart_props u_props (
  .clk(clk), .rst_b(rst_b), .port_addr(port_addr), .port_wr(port_wr),
  .port_rd(port_rd), .port_wdata(port_wdata), .port_rdata(port_rdata),
  .midi_irq(midi_irq), .uart_mode(uart_mode), .midi_serial_out(midi_serial_out),
  .midi_serial_in(midi_serial_in)
);

`default_nettype wire

/* bench/mue_uart_bench.sv */
/*
  Self-checking bench for the emulator: host port tasks, MIDI partner.
  Assumes the design files under core/ and the partner and checker.
*/
`timescale 1ns/100ps
`default_nettype none

module mue_uart_bench;
  logic       clk;
  logic       rst_b;
  logic       port_addr;
  logic       port_wr;
  logic       port_rd;
  logic [7:0] port_wdata;
  wire  [7:0] port_rdata;
  wire        midi_irq;
  wire        uart_mode;
  wire        midi_serial_out;
  wire        midi_serial_in;
  int         err_total;
  int         n_tests;
  logic [7:0] cmds [12] = '{8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7,
                            8'hab, 8'hac, 8'had, 8'haf};

  mue_uart dut (
    .clk(clk), .rst_b(rst_b), .port_addr(port_addr), .port_wr(port_wr),
    .port_rd(port_rd), .port_wdata(port_wdata), .port_rdata(port_rdata),
    .midi_irq(midi_irq), .uart_mode(uart_mode), .midi_serial_out(midi_serial_out),
    .midi_serial_in(midi_serial_in)
  );
  mue_midi_dev dev (.clk(clk), .line_in(midi_serial_out), .line_out(midi_serial_in));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Host port tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic a, input logic [7:0] d);
    @(posedge clk);
    port_addr  <= a;
    port_wdata <= d;
    port_wr    <= 1'b1;
    @(posedge clk);
    port_wr <= 1'b0;
  endtask
  // Data lands on the taking edge itself
  task automatic rd(input logic a, input logic [7:0] exp);
    @(posedge clk);
    port_addr <= a;
    port_rd   <= 1'b1;
    @(posedge clk);
    port_rd <= 1'b0;
    #1 chk(port_rdata, exp);
  endtask
  function automatic logic [7:0] reply(input logic [7:0] c);
    case (c)
      8'hac:   return 8'h15;
      8'had:   return 8'h01;
      8'haf:   return 8'h64;
      default: return 8'h00;
    endcase
  endfunction
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    port_addr = 1'b0;
    port_wr = 1'b0;
    port_rd = 1'b0;
    port_wdata = 8'h00;
    err_total = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk_bit(uart_mode, 1'b0);
    rd(1'b1, 8'h80);
    wr(1'b0, 8'h12);
    rd(1'b1, 8'h80);
    $display("test reset done");
    foreach (cmds[i]) begin
      wr(1'b1, cmds[i]);
      #1 chk_bit(midi_irq, 1'b1);
      rd(1'b0, 8'hfe);
      chk_bit(midi_irq, 1'b0);
      wr(1'b1, 8'h3f);
      #1 chk_bit(uart_mode, 1'b1);
      wr(1'b1, 8'ha0);
      rd(1'b0, 8'hfe);
      rd(1'b0, reply(cmds[i]));
      rd(1'b0, 8'hfe);
      rd(1'b1, 8'h80);
      wr(1'b1, 8'hff);
      #1 chk_bit(uart_mode, 1'b0);
    end
    $display("test commands done");
    wr(1'b1, 8'h3f);
    rd(1'b0, 8'hfe);
    rd(1'b1, 8'h80);
    // One byte sits in the shifter, so seventeen fill the queue
    for (int i = 0; i < 17; i++) wr(1'b0, 8'ha5 ^ i[7:0]);
    rd(1'b1, 8'hc0);
    for (int k = 0; k < 20000 && dev.rx_q.size() < 2; k++) @(posedge clk);
    chk(dev.rx_q[0], 8'ha5);
    chk(dev.rx_q[1], 8'ha4);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk_bit(midi_serial_out, 1'b1);
    $display("test transmit done");
    repeat (15) wr(1'b1, 8'h21);
    #1 chk_bit(uart_mode, 1'b0);
    wr(1'b1, 8'h3f);
    rd(1'b0, 8'hfe);
    chk_bit(midi_irq, 1'b0);
    dev.send_byte(8'h5a);
    chk_bit(midi_irq, 1'b1);
    // Queue is full now, so the next byte replaces the last slot
    dev.send_byte(8'hc3);
    rd(1'b1, 8'h00);
    for (int i = 0; i < 15; i++) rd(1'b0, 8'hfe);
    rd(1'b0, 8'hc3);
    rd(1'b1, 8'h80);
    $display("test receive done");
    finish_test();
  end

  // Whole run is near 32000 cycles; allow about twice that
  initial begin
    #3000000;
    err_total++;
    $display("ERROR %0t watchdog expired", $time);
    finish_test();
  end
endmodule // mue_uart_bench

`default_nettype wire
